// ---- rtl/osd_top.sv ----
// Out-of-step detector: half-period timing, threshold, blocking and trip hold.
`timescale 1ns/10ps
module osd_top #(
	parameter int SW = 16,
	parameter int CW = 24,
	parameter int TICK_CYCLES = osd_pkg::TICK_CYCLES
) (
	// Clock and reset
	input wire logic core_clk_i,
	input wire logic sys_rst_i,
	// Voltage samples
	input wire logic sample_stb_i,
	input wire logic signed [SW-1:0] va_sample_i,
	input wire logic signed [SW-1:0] vab_sample_i,
	input wire logic phase_to_phase_i,
	// Settings
	input wire logic enable_setting_i,
	input wire logic [4:0] angle_deg_i,
	input wire logic [6:0] freq_hz_i,
	input wire logic [SW-2:0] block_voltage_i,
	input wire logic [15:0] block_time_cs_i,
	input wire logic [15:0] hold_time_cs_i,
	input wire logic trip_mask_i,
	// Plant and digital inputs
	input wire logic breaker_closed_i,
	input wire logic element_enable_input_i,
	input wire logic element_block_input_i,
	// Trips
	output logic unmasked_trip_o,
	output logic masked_trip_o,
	// Status and events
	output logic temporary_block_status_o,
	output logic min_voltage_block_status_o,
	output logic element_enabled_status_o,
	output logic element_block_input_status_o,
	output logic element_enable_input_status_o,
	output logic [osd_pkg::EVT_W-1:0] status_event_o
);
	import osd_pkg::*;

	localparam int TW = $clog2(TICK_CYCLES);
	localparam logic [TW-1:0] TICK_LAST = TW'(TICK_CYCLES - 1);
	localparam logic [CW-1:0] CNT_SAT = '1;

	// ----------------------------------------
	// Step divider
	// ----------------------------------------
	logic [TW-1:0] tick_cnt_r;
	logic [TW-1:0] tick_cnt_nxt;
	logic tick_r;
	logic tick_nxt;

	always_comb begin
		tick_nxt = (tick_cnt_r == TICK_LAST);
		tick_cnt_nxt = tick_nxt ? '0 : tick_cnt_r + TW'(1);
	end

	always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			tick_cnt_r <= '0;
			tick_r <= 1'b0;
		end else begin
			tick_cnt_r <= tick_cnt_nxt;
			tick_r <= tick_nxt;
		end
	end

	// ----------------------------------------
	// Setting limits
	// ----------------------------------------
	function automatic logic [15:0] clamp16(input logic [15:0] v, input logic [15:0] lo, input logic [15:0] hi);
		clamp16 = (v < lo) ? lo : ((v > hi) ? hi : v);
	endfunction : clamp16

	logic [4:0] angle;
	assign angle = (angle_deg_i < ANGLE_MIN) ? ANGLE_MIN :
		((angle_deg_i > ANGLE_MAX) ? ANGLE_MAX : angle_deg_i);

	// ----------------------------------------
	// Timers
	// ----------------------------------------
	osd_tmr_if #(.W(16)) blk_tmr ();
	osd_tmr_if #(.W(16)) hold_tmr ();

	osd_timer u_blk_timer (
		.core_clk_i(core_clk_i),
		.sys_rst_i(sys_rst_i),
		.tick_i(tick_r),
		.t(blk_tmr.tmr)
	);

	osd_timer u_hold_timer (
		.core_clk_i(core_clk_i),
		.sys_rst_i(sys_rst_i),
		.tick_i(tick_r),
		.t(hold_tmr.tmr)
	);

	// ----------------------------------------
	// Measurement and detection state
	// ----------------------------------------
	logic signed [SW-1:0] meas;
	logic [SW-2:0] meas_abs;
	logic neg_r, neg_nxt;
	logic sign_ok_r, sign_ok_nxt;
	logic [CW-1:0] cnt_r, cnt_nxt;
	logic [CW-1:0] pos_half_r, pos_half_nxt;
	logic [CW-1:0] neg_half_r, neg_half_nxt;
	logic pos_ok_r, pos_ok_nxt;
	logic neg_ok_r, neg_ok_nxt;
	logic [SW-2:0] peak_r, peak_nxt;
	logic [SW-2:0] half_peak_r, half_peak_nxt;
	logic det_r, det_nxt;
	logic crossing;
	logic [CW-1:0] prev_same;
	logic [CW-1:0] abs_diff;
	logic [39:0] diff_scaled;
	logic [39:0] angle_scaled;
	logic volt_present;
	logic enabled_now;
	logic trip_r, trip_nxt;
	logic masked_r, masked_nxt;
	logic temp_blk_r, temp_blk_nxt;
	logic minv_r, minv_nxt;
	logic [EVT_W-1:0] stat_r, stat_nxt;
	logic [EVT_W-1:0] evt_r, evt_nxt;

	assign meas = phase_to_phase_i ? vab_sample_i : va_sample_i;
	assign meas_abs = meas[SW-1] ? (SW-1)'(-meas) : meas[SW-2:0];
	assign crossing = sample_stb_i && sign_ok_r && (meas[SW-1] != neg_r);
	assign prev_same = neg_r ? neg_half_r : pos_half_r;
	assign abs_diff = (cnt_r >= prev_same) ? cnt_r - prev_same : prev_same - cnt_r;
	// Cross-multiplied so no divider is needed: |dt| * 360 * F >= angle * clock rate.
	assign diff_scaled = 40'(abs_diff) * 40'(DEG_PER_CYCLE) * 40'(freq_hz_i);
	assign angle_scaled = 40'(angle) * 40'(CLK_HZ);
	// A stalled counter means no crossings, so the voltage counts as absent.
	assign volt_present = (half_peak_r >= block_voltage_i) && (cnt_r != CNT_SAT);
	assign enabled_now = enable_setting_i && element_enable_input_i && breaker_closed_i;

	assign blk_tmr.run = volt_present;
	assign blk_tmr.restart = 1'b0;
	assign blk_tmr.limit = clamp16(block_time_cs_i, BLK_TIME_MIN, BLK_TIME_MAX);
	assign hold_tmr.run = trip_r;
	assign hold_tmr.restart = det_r;
	assign hold_tmr.limit = clamp16(hold_time_cs_i, HOLD_TIME_MIN, HOLD_TIME_MAX);

	always_comb begin
		neg_nxt = neg_r;
		sign_ok_nxt = sign_ok_r;
		cnt_nxt = (cnt_r == CNT_SAT) ? cnt_r : cnt_r + CW'(1);
		pos_half_nxt = pos_half_r;
		neg_half_nxt = neg_half_r;
		pos_ok_nxt = pos_ok_r;
		neg_ok_nxt = neg_ok_r;
		peak_nxt = peak_r;
		half_peak_nxt = half_peak_r;
		det_nxt = 1'b0;
		if (sample_stb_i) begin
			neg_nxt = meas[SW-1];
			sign_ok_nxt = 1'b1;
			if (meas_abs > peak_r) begin
				peak_nxt = meas_abs;
			end
		end
		if (crossing) begin
			cnt_nxt = '0;
			peak_nxt = meas_abs;
			half_peak_nxt = peak_r;
			if (cnt_r == CNT_SAT) begin
				pos_ok_nxt = 1'b0;
				neg_ok_nxt = 1'b0;
			end else begin
				det_nxt = (neg_r ? neg_ok_r : pos_ok_r) && (diff_scaled >= angle_scaled);
				if (neg_r) begin
					neg_half_nxt = cnt_r;
					neg_ok_nxt = 1'b1;
				end else begin
					pos_half_nxt = cnt_r;
					pos_ok_nxt = 1'b1;
				end
			end
		end
		minv_nxt = !volt_present;
		temp_blk_nxt = !blk_tmr.done;
		trip_nxt = trip_r;
		if (element_block_input_i || !enabled_now) begin
			trip_nxt = 1'b0;
		end else if (det_r && !temp_blk_r && !minv_r) begin
			trip_nxt = 1'b1;
		end else if (hold_tmr.done) begin
			trip_nxt = 1'b0;
		end
		masked_nxt = trip_nxt && trip_mask_i;
		stat_nxt = '0;
		stat_nxt[EVT_TEMP_BLK] = temp_blk_nxt;
		stat_nxt[EVT_MIN_V] = minv_nxt;
		stat_nxt[EVT_ENABLED] = enabled_now;
		stat_nxt[EVT_BLK_IN] = element_block_input_i;
		stat_nxt[EVT_EN_IN] = element_enable_input_i;
		evt_nxt = stat_nxt ^ stat_r;
	end

	always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			neg_r <= 1'b0;
			sign_ok_r <= 1'b0;
			cnt_r <= '0;
			pos_half_r <= '0;
			neg_half_r <= '0;
			pos_ok_r <= 1'b0;
			neg_ok_r <= 1'b0;
			peak_r <= '0;
			half_peak_r <= '0;
			det_r <= 1'b0;
			minv_r <= 1'b1;
			temp_blk_r <= TEMP_BLOCK_RST;
			trip_r <= 1'b0;
			masked_r <= 1'b0;
			// Statuses that reset high start high here too, so release gives no false event.
			stat_r <= '0;
			stat_r[EVT_TEMP_BLK] <= TEMP_BLOCK_RST;
			stat_r[EVT_MIN_V] <= 1'b1;
			evt_r <= '0;
		end else begin
			neg_r <= neg_nxt;
			sign_ok_r <= sign_ok_nxt;
			cnt_r <= cnt_nxt;
			pos_half_r <= pos_half_nxt;
			neg_half_r <= neg_half_nxt;
			pos_ok_r <= pos_ok_nxt;
			neg_ok_r <= neg_ok_nxt;
			peak_r <= peak_nxt;
			half_peak_r <= half_peak_nxt;
			det_r <= det_nxt;
			minv_r <= minv_nxt;
			temp_blk_r <= temp_blk_nxt;
			trip_r <= trip_nxt;
			masked_r <= masked_nxt;
			stat_r <= stat_nxt;
			evt_r <= evt_nxt;
		end
	end

	assign unmasked_trip_o = trip_r;
	assign masked_trip_o = masked_r;
	assign temporary_block_status_o = temp_blk_r;
	assign min_voltage_block_status_o = minv_r;
	assign element_enabled_status_o = stat_r[EVT_ENABLED];
	assign element_block_input_status_o = stat_r[EVT_BLK_IN];
	assign element_enable_input_status_o = stat_r[EVT_EN_IN];
	assign status_event_o = evt_r;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (sys_rst_i);

	chk_masked_trip: assert property (masked_trip_o |-> unmasked_trip_o)
		else $error("masked trip without unmasked trip");
	chk_breaker_open: assert property (!breaker_closed_i |=> !element_enabled_status_o && !unmasked_trip_o)
		else $error("element active with breaker open");
	chk_block_resets: assert property (element_block_input_i |=> !unmasked_trip_o)
		else $error("trip survived block input");
	chk_trip_cause: assert property ($rose(unmasked_trip_o) |-> $past(det_r) && !$past(temp_blk_r) && !$past(minv_r))
		else $error("trip rose without unblocked detection");
	chk_det_crossing: assert property (det_r |-> $past(crossing) && $past(diff_scaled >= angle_scaled))
		else $error("detection without crossing over threshold");
	chk_event_change: assert property (status_event_o[EVT_TEMP_BLK] |-> $changed(temporary_block_status_o))
		else $error("event without status change");
	chk_low_v_block: assert property (minv_r |=> temporary_block_status_o)
		else $error("temporary block released without voltage");
	chk_trip_hold: assert property ($fell(unmasked_trip_o) |-> $past(hold_tmr.done) ||
		$past(element_block_input_i) || !$past(enabled_now))
		else $error("trip dropped before hold time");
	chk_angle_range: assert property (angle >= ANGLE_MIN && angle <= ANGLE_MAX &&
		(angle == angle_deg_i || angle_deg_i < ANGLE_MIN || angle_deg_i > ANGLE_MAX))
		else $error("angle outside range");
endmodule : osd_top

// ---- rtl/osd_pkg.sv ----
// Constants shared by the out-of-step detector modules.
package osd_pkg;
	// ----------------------------------------
	// Clock and timing
	// ----------------------------------------
	localparam int unsigned CLK_HZ = 100_000_000;
	localparam int unsigned MS_PER_S = 1000;
	localparam int unsigned TIMER_STEP_MS = 10;
	localparam int unsigned TICK_CYCLES = CLK_HZ / MS_PER_S * TIMER_STEP_MS;
	localparam int unsigned DEG_PER_CYCLE = 360;
	// ----------------------------------------
	// Setting ranges and defaults
	// ----------------------------------------
	localparam logic [4:0] ANGLE_MIN = 5'h01;
	localparam logic [4:0] ANGLE_MAX = 5'h19;
	localparam logic [4:0] ANGLE_RST = 5'h01;
	localparam logic [15:0] BLK_TIME_MIN = 16'h0005;
	localparam logic [15:0] BLK_TIME_MAX = 16'h0BB8;
	localparam logic [15:0] BLK_TIME_RST = 16'h0005;
	localparam logic [15:0] HOLD_TIME_MIN = 16'h000A;
	localparam logic [15:0] HOLD_TIME_MAX = 16'h7530;
	localparam logic [15:0] HOLD_TIME_RST = 16'h000A;
	localparam logic ENABLE_SETTING_RST = 1'b0;
	localparam logic ENABLE_INPUT_RST = 1'b1;
	localparam logic TEMP_BLOCK_RST = 1'b1;
	// ----------------------------------------
	// Status event bit positions
	// ----------------------------------------
	localparam int unsigned EVT_TEMP_BLK = 0;
	localparam int unsigned EVT_MIN_V = 1;
	localparam int unsigned EVT_ENABLED = 2;
	localparam int unsigned EVT_BLK_IN = 3;
	localparam int unsigned EVT_EN_IN = 4;
	localparam int unsigned EVT_W = 5;
endpackage : osd_pkg

// ---- rtl/osd_tmr_if.sv ----
// Control and status lines between the detector core and one settable timer.
`timescale 1ns/10ps
interface osd_tmr_if #(parameter int W = 16);
	logic restart;
	logic run;
	logic [W-1:0] limit;
	logic done;
	modport ctl (output restart, output run, output limit, input done);
	modport tmr (input restart, input run, input limit, output done);
endinterface : osd_tmr_if

// ---- rtl/osd_timer.sv ----
// Settable timer counting 10 ms steps while its run line is high.
`timescale 1ns/10ps
module osd_timer (
	// Clock and reset
	input wire logic core_clk_i,
	input wire logic sys_rst_i,
	// Step enable
	input wire logic tick_i,
	// Control
	osd_tmr_if.tmr t
);
	logic [15:0] count_r;
	logic [15:0] count_nxt;

	always_comb begin
		count_nxt = count_r;
		if (t.restart || !t.run) begin
			count_nxt = '0;
		end else if (tick_i && count_r < t.limit) begin
			count_nxt = count_r + 16'h0001;
		end
	end

	always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			count_r <= '0;
		end else begin
			count_r <= count_nxt;
		end
	end

	assign t.done = t.run && !t.restart && (count_r >= t.limit);
endmodule : osd_timer

// ---- dv/osd_src.sv ----
// Voltage source model feeding square-wave samples to the detector.
`timescale 1ns/10ps
module osd_src (
	// Clock
	input wire logic core_clk_i,
	// Samples
	output logic sample_stb_o,
	output logic signed [15:0] va_o,
	output logic signed [15:0] vab_o
);
	// The AB channel stays positive, so it never shows a crossing.
	initial begin
		sample_stb_o = 1'b0;
		va_o = 16'sh0000;
		vab_o = 16'sh03E8;
	end
	// ----------------------------------------
	// Waveform
	// ----------------------------------------
	// One sample per clock: p cycles at +a, then n cycles at -a, k times over.
	task automatic run(input int p, input int n, input int k, input logic signed [15:0] a);
		for (int i = 0; i < k * (p + n); i++) begin
			@(posedge core_clk_i);
			#1;
			sample_stb_o = 1'b1;
			va_o = (i % (p + n) < p) ? a : -a;
		end
		// A released channel must not look like a held sample.
		@(posedge core_clk_i);
		#1;
		sample_stb_o = 1'b0;
		va_o = ~va_o;
	endtask : run
endmodule : osd_src

// ---- dv/tb_top.sv ----
// Self-checking bench for the out-of-step detector.
`timescale 1ns/10ps
module tb_top;
	import osd_pkg::*;
	logic core_clk_i, sys_rst_i, sample_stb_i, phase_to_phase_i, enable_setting_i, trip_mask_i;
	logic breaker_closed_i, element_enable_input_i, element_block_input_i;
	logic signed [15:0] va_sample_i, vab_sample_i;
	logic [4:0] angle_deg_i;
	logic unmasked_trip_o, masked_trip_o, temporary_block_status_o, min_voltage_block_status_o;
	logic element_enabled_status_o, element_block_input_status_o, element_enable_input_status_o;
	logic [EVT_W-1:0] status_event_o;
	int err_count, samples_checked;
	// ----------------------------------------
	// Instances
	// ----------------------------------------
	// Short steps keep timers at 10 clock cycles per 10 ms step.
	osd_top #(.TICK_CYCLES(10)) u_osd_top (.core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i),
		.sample_stb_i(sample_stb_i), .va_sample_i(va_sample_i), .vab_sample_i(vab_sample_i),
		.phase_to_phase_i(phase_to_phase_i), .enable_setting_i(enable_setting_i), .angle_deg_i(angle_deg_i),
		.freq_hz_i(7'h64), .block_voltage_i(15'h0064), .block_time_cs_i(16'h0005),
		.hold_time_cs_i(16'h000A), .trip_mask_i(trip_mask_i), .breaker_closed_i(breaker_closed_i),
		.element_enable_input_i(element_enable_input_i), .element_block_input_i(element_block_input_i),
		.unmasked_trip_o(unmasked_trip_o), .masked_trip_o(masked_trip_o),
		.temporary_block_status_o(temporary_block_status_o),
		.min_voltage_block_status_o(min_voltage_block_status_o),
		.element_enabled_status_o(element_enabled_status_o),
		.element_block_input_status_o(element_block_input_status_o),
		.element_enable_input_status_o(element_enable_input_status_o), .status_event_o(status_event_o));
	osd_src u_osd_src (.core_clk_i(core_clk_i), .sample_stb_o(sample_stb_i), .va_o(va_sample_i),
		.vab_o(vab_sample_i));
	always #5 core_clk_i = ~core_clk_i;
	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		samples_checked++;
		if (got !== exp) begin
			err_count++;
			$display("unexpected %s: expected %0h seen %0h", what, exp, got);
		end
	endtask : check
	task automatic complete_run();
		$display("checks %0d mismatches %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : complete_run
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic temp_block_release();
		int n;
		n = 0;
		fork
			u_osd_src.run(500, 500, 4, 16'sh03E8);
			while (temporary_block_status_o === 1'b1 && n < 4000) begin
				@(posedge core_clk_i);
				#2;
				n++;
			end
		join
		check("temp block time", 1, n >= 40 && n < 4000);
		check("min v block", 0, min_voltage_block_status_o);
		if (n >= 4000) complete_run();
		$display("test temp_block_release done");
	endtask : temp_block_release
	// Step of dt cycles in one positive half; c = {mask, ptp, breaker, en_in, block, setting}.
	task automatic oos(input string nm, input int dt, input logic [15:0] a, input logic [5:0] c, input bit exp);
		int cu;
		int cm;
		cu = 0;
		cm = 0;
		@(posedge core_clk_i);
		#1;
		{trip_mask_i, phase_to_phase_i, breaker_closed_i, element_enable_input_i, element_block_input_i,
			enable_setting_i} = c;
		u_osd_src.run(500, 500, 2, a);
		check("enabled status", c[0] & c[2] & c[3], element_enabled_status_o);
		check("block in status", c[1], element_block_input_status_o);
		check("enable in status", c[2], element_enable_input_status_o);
		if (!c[4]) check("min v status", a < 16'h0064, min_voltage_block_status_o);
		fork
			begin
				u_osd_src.run(500 + dt, 500, 1, a);
				u_osd_src.run(500, 500, 2, a);
			end
			repeat (3100 + dt) begin
				@(posedge core_clk_i);
				#2;
				cu += (unmasked_trip_o === 1'b1);
				cm += (masked_trip_o === 1'b1);
			end
		join
		// Two detections, each held for 100 cycles give or take one step.
		check("trip hold", exp, cu >= 180 && cu <= 224);
		if (!exp) check("trip cycles", 0, cu);
		check("masked trip", c[5] ? cu : 0, cm);
		$display("test %s done", nm);
	endtask : oos
	task automatic block_after_trip();
		int n;
		int ev;
		n = 0;
		ev = 0;
		// The previous scenario leaves the AB channel selected, which never crosses zero.
		@(posedge core_clk_i);
		#1;
		{trip_mask_i, phase_to_phase_i, breaker_closed_i, element_enable_input_i, element_block_input_i,
			enable_setting_i} = 6'b101101;
		u_osd_src.run(500, 500, 2, 16'sh03E8);
		fork
			u_osd_src.run(3500, 500, 1, 16'sh03E8);
			begin
				while (unmasked_trip_o !== 1'b1 && n < 5000) begin
					@(posedge core_clk_i);
					#2;
					n++;
				end
				@(posedge core_clk_i);
				#1;
				element_block_input_i = 1'b1;
				repeat (2) begin
					@(posedge core_clk_i);
					#2;
					ev += (status_event_o[EVT_BLK_IN] === 1'b1);
				end
			end
		join
		check("trip seen", 1, n < 5000);
		check("trip after block", 0, unmasked_trip_o);
		check("block event", 1, ev);
		if (n >= 5000) complete_run();
		$display("test block_after_trip done");
	endtask : block_after_trip
	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		core_clk_i = 1'b0;
		sys_rst_i = 1'b1;
		{trip_mask_i, phase_to_phase_i, breaker_closed_i, element_enable_input_i, element_block_input_i,
			enable_setting_i} = 6'b101101;
		err_count = 0;
		samples_checked = 0;
		angle_deg_i = 5'h01;
		repeat (12) @(posedge core_clk_i);
		#1;
		check("reset trip", 0, {unmasked_trip_o, masked_trip_o, status_event_o});
		check("reset blocks", 3, {temporary_block_status_o, min_voltage_block_status_o});
		sys_rst_i = 1'b0;
		temp_block_release();
		oos("below_threshold", 2777, 16'h03E8, 6'b101101, 1'b0);
		oos("at_threshold", 2778, 16'h03E8, 6'b101101, 1'b1);
		// An angle of zero is clamped to one degree, so the threshold stays the same.
		@(posedge core_clk_i);
		#1;
		angle_deg_i = 5'h00;
		oos("mask_off", 2778, 16'h03E8, 6'b001101, 1'b1);
		oos("breaker_open", 3000, 16'h03E8, 6'b100101, 1'b0);
		oos("enable_input_low", 3000, 16'h03E8, 6'b101001, 1'b0);
		oos("setting_off", 3000, 16'h03E8, 6'b101100, 1'b0);
		oos("block_before", 3000, 16'h03E8, 6'b101111, 1'b0);
		oos("low_voltage", 3000, 16'h0032, 6'b101101, 1'b0);
		oos("ab_selected", 3000, 16'h03E8, 6'b111101, 1'b0);
		block_after_trip();
		complete_run();
	end
endmodule : tb_top
